// ---- afo_pkg.sv ----
// Constants for the sample output formatter
package afo_pkg;

  // ----------------------------------------------------------------
  // Sample word
  // ----------------------------------------------------------------
  localparam int          WORD_W    = 13;
  localparam int          RAW_W     = 14;
  localparam int          CORR_W    = 16;
  localparam logic [12:0] MID_CODE  = 13'h1000;
  localparam logic [12:0] ALL_ONES  = 13'h1fff;
  localparam logic [12:0] ALL_ZEROS = 13'h0000;
  localparam int          MSB_POS   = 12;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  localparam int          NUM_PINS  = 5;
  localparam int          PIN_SCLK  = 0;
  localparam int          PIN_FMT   = 1;
  localparam int          PIN_OEN   = 2;
  localparam int          PIN_PDN   = 3;
  localparam int          PIN_CKEN  = 4;
  localparam logic [4:0]  SYNC_RST  = 5'h14;
  localparam int          DCLK_LAG  = 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_TRIM     = 8'h04;
  localparam logic [7:0]  ADR_STAT     = 8'h08;
  localparam logic [7:0]  ADR_IRQ_STAT = 8'h0c;
  localparam logic [7:0]  ADR_IRQ_MASK = 8'h10;
  localparam logic [7:0]  ADR_COUNT    = 8'h14;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_TWELVE  = 0;
  localparam int          STAT_FLAG    = 16;
  localparam int          STAT_PINS    = 20;
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_OVER     = 0;
  localparam int          IRQ_UNDER    = 1;
  localparam int          IRQ_PDOWN    = 2;
  localparam logic        CTRL_RST     = 1'h0;
  localparam logic [13:0] TRIM_RST     = 14'h0000;
  localparam logic [2:0]  MASK_RST     = 3'h0;
  localparam logic [15:0] COUNT_RST    = 16'h0000;

endpackage : afo_pkg

// ---- afo_pins_if.sv ----
// Interface carrying raw pins and their synchronised levels
`timescale 1ns/1ps
interface afo_pins_if;
  logic [4:0] raw;
  logic [4:0] level;
  logic       sclk_rise;

  modport syncer (input raw, output level, output sclk_rise);
  modport user   (output raw, input level, input sclk_rise);
endinterface : afo_pins_if

// ---- afo_pin_sync.sv ----
// Three-stage synchronisers for the control pins and input clock
`timescale 1ns/1ps
module afo_pin_sync (
  // Clock and reset
  input  wire logic   ref_clk_in,
  input  wire logic   sys_rst_in,
  // Pins
  afo_pins_if.syncer  pins
);

  logic [4:0] s1_ff;
  logic [4:0] s2_ff;
  logic [4:0] s3_ff;
  logic [4:0] level_ff;
  logic       rise_ff;

  // ----------------------------------------------------------------
  // Per-pin chain; a level counts only once stages two and three agree
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < afo_pkg::NUM_PINS; i++) begin : g_pin
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          s1_ff[i]    <= afo_pkg::SYNC_RST[i];
          s2_ff[i]    <= afo_pkg::SYNC_RST[i];
          s3_ff[i]    <= afo_pkg::SYNC_RST[i];
          level_ff[i] <= afo_pkg::SYNC_RST[i];
        end else begin
          s1_ff[i] <= pins.raw[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          if (s2_ff[i] == s3_ff[i]) begin
            level_ff[i] <= s3_ff[i];
          end
        end
      end
    end
  endgenerate

  // Rising edge of the input clock only; falling edges are dropped
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rise_ff <= 1'b0;
    end else begin
      rise_ff <= s2_ff[afo_pkg::PIN_SCLK] & s3_ff[afo_pkg::PIN_SCLK]
               & ~level_ff[afo_pkg::PIN_SCLK];
    end
  end

  assign pins.level     = level_ff;
  assign pins.sclk_rise = rise_ff;

endmodule : afo_pin_sync

// ---- afo_formatter.sv ----
// Sample output formatter: offset centring, clamping, coding, pin drive
`timescale 1ns/1ps
module afo_formatter (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // Converter side
  input  wire logic        sample_clk_in,
  input  wire logic [13:0] raw_sample_in,
  // Control pins
  input  wire logic        format_select_in,
  input  wire logic        output_enable_low_in,
  input  wire logic        power_down_low_in,
  input  wire logic        data_clock_out_enable_low_in,
  // Parallel output pins
  output logic [12:0]      data_out,
  output logic [12:0]      data_oe_out,
  output logic             range_flag_out,
  output logic             data_clock_out,
  output logic             data_clock_oe_out,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // Interrupt
  output logic             irq_out
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction : lane_mask

  function automatic logic flag_of(input logic [12:0] w, input logic twelve);
    logic hi_same;
    hi_same = (&w[12:1]) | ~(|w[12:1]);
    if (twelve) begin
      return hi_same & (w[0] == w[1]);
    end
    return (&w) | ~(|w);
  endfunction : flag_of

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  afo_pins_if pins ();

  assign pins.raw = {data_clock_out_enable_low_in, power_down_low_in,
                     output_enable_low_in, format_select_in, sample_clk_in};

  afo_pin_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .pins       (pins)
  );

  logic rise;
  logic fmt_s;
  logic oen_s;
  logic pdn_s;
  logic cken_s;

  assign rise   = pins.sclk_rise;
  assign fmt_s  = pins.level[afo_pkg::PIN_FMT];
  assign oen_s  = pins.level[afo_pkg::PIN_OEN];
  assign pdn_s  = pins.level[afo_pkg::PIN_PDN];
  assign cken_s = pins.level[afo_pkg::PIN_CKEN];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic        twelve_ff;
  logic [13:0] trim_ff;
  logic [2:0]  irq_stat_ff;
  logic [2:0]  irq_mask_ff;
  logic [15:0] count_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        irq_ff;
  logic        pdn_prev_ff;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic               stage_vld_ff;
  logic signed [15:0] corr_ff;
  logic signed [15:0] nxt_corr;
  logic signed [15:0] trim_ext;
  logic signed [15:0] hi_lim;
  logic [12:0]        nxt_ob;
  logic               nxt_over;
  logic               nxt_under;
  logic [12:0]        data_ff;
  logic               range_ff;
  logic               fmt_ff;
  logic               upd_ff;
  logic [2:0]         dly_ff;
  logic               dclk_ff;
  logic               dclk_oe_ff;
  logic [12:0]        data_oe_ff;

  assign trim_ext = $signed({{2{trim_ff[13]}}, trim_ff});
  assign hi_lim   = $signed({3'b000, afo_pkg::ALL_ONES});

  // Centre the result digitally so that zero input lands on mid-scale
  always_comb begin
    nxt_corr = $signed({3'b000, afo_pkg::MID_CODE})
             + $signed({{2{raw_sample_in[13]}}, raw_sample_in})
             - trim_ext;
  end

  // Stage one: capture on the input clock's rising edge only
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !pdn_s) begin
      stage_vld_ff <= 1'b0;
      corr_ff      <= 16'sh0000;
    end else begin
      stage_vld_ff <= rise;
      if (rise) begin
        corr_ff <= nxt_corr;
      end
    end
  end

  // Clamp: the centred code clips before the raw code would wrap
  always_comb begin
    nxt_over  = 1'b0;
    nxt_under = 1'b0;
    if (corr_ff > hi_lim) begin
      nxt_ob   = afo_pkg::ALL_ONES;
      nxt_over = 1'b1;
    end else if (corr_ff < 16'sh0000) begin
      nxt_ob    = afo_pkg::ALL_ZEROS;
      nxt_under = 1'b1;
    end else begin
      nxt_ob = corr_ff[12:0];
    end
  end

  // Stage two: coding and flag; flag judged on the offset-binary word
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !pdn_s) begin
      data_ff  <= afo_pkg::ALL_ZEROS;
      range_ff <= 1'b0;
      fmt_ff   <= 1'b0;
      upd_ff   <= 1'b0;
    end else begin
      upd_ff <= stage_vld_ff;
      if (stage_vld_ff) begin
        data_ff  <= {nxt_ob[12] ^ fmt_s, nxt_ob[11:0]};
        range_ff <= flag_of(nxt_ob, twelve_ff);
        fmt_ff   <= fmt_s;
      end
    end
  end

  // Data clock lags the input clock so the word has settled at its rise
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !pdn_s) begin
      dly_ff  <= 3'h0;
      dclk_ff <= 1'b0;
    end else begin
      dly_ff  <= {dly_ff[1:0], pins.level[afo_pkg::PIN_SCLK]};
      dclk_ff <= dly_ff[afo_pkg::DCLK_LAG-1];
    end
  end

  // Pin enables; bit 0 stays driven in twelve-bit use, the receiver ignores it
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      data_oe_ff <= 13'h0000;
      dclk_oe_ff <= 1'b0;
    end else begin
      data_oe_ff <= oen_s ? 13'h0000 : afo_pkg::ALL_ONES;
      dclk_oe_ff <= ~cken_s;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave: one-cycle registered ack, zero for unmapped reads
  // ----------------------------------------------------------------
  logic        req;
  logic        wr;
  logic [31:0] wm;

  assign req = wb_cyc_in & wb_stb_in & ~ack_ff;
  assign wr  = req & wb_we_in;
  assign wm  = lane_mask(wb_sel_in);

  // Acknowledge and read mux
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= req;
      if (req && !wb_we_in) begin
        unique case (wb_adr_in)
          afo_pkg::ADR_CTRL:     dat_ff <= {31'h0, twelve_ff};
          afo_pkg::ADR_TRIM:     dat_ff <= {18'h0, trim_ff};
          afo_pkg::ADR_STAT:     dat_ff <= {7'h0, pins.level, 3'h0, range_ff,
                                            3'h0, data_ff};
          afo_pkg::ADR_IRQ_STAT: dat_ff <= {29'h0, irq_stat_ff};
          afo_pkg::ADR_IRQ_MASK: dat_ff <= {29'h0, irq_mask_ff};
          afo_pkg::ADR_COUNT:    dat_ff <= {16'h0, count_ff};
          default:               dat_ff <= 32'h0;
        endcase
      end
    end
  end

  // Software-written controls
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      twelve_ff   <= afo_pkg::CTRL_RST;
      trim_ff     <= afo_pkg::TRIM_RST;
      irq_mask_ff <= afo_pkg::MASK_RST;
    end else if (wr) begin
      if (wb_adr_in == afo_pkg::ADR_CTRL && wm[afo_pkg::CTRL_TWELVE]) begin
        twelve_ff <= wb_dat_in[afo_pkg::CTRL_TWELVE];
      end
      if (wb_adr_in == afo_pkg::ADR_TRIM) begin
        trim_ff <= (trim_ff & ~wm[13:0]) | (wb_dat_in[13:0] & wm[13:0]);
      end
      if (wb_adr_in == afo_pkg::ADR_IRQ_MASK) begin
        irq_mask_ff <= (irq_mask_ff & ~wm[2:0]) | (wb_dat_in[2:0] & wm[2:0]);
      end
    end
  end

  // Updated-word counter, cleared by any write to it
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      count_ff <= afo_pkg::COUNT_RST;
    end else if (wr && wb_adr_in == afo_pkg::ADR_COUNT) begin
      count_ff <= afo_pkg::COUNT_RST;
    end else if (upd_ff) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky, write one to clear, a new event beats the clear
  // ----------------------------------------------------------------
  logic [2:0] ev;
  logic [2:0] clr;

  assign ev[afo_pkg::IRQ_OVER]  = stage_vld_ff & nxt_over;
  assign ev[afo_pkg::IRQ_UNDER] = stage_vld_ff & nxt_under;
  assign ev[afo_pkg::IRQ_PDOWN] = pdn_prev_ff & ~pdn_s;
  assign clr = (wr && wb_adr_in == afo_pkg::ADR_IRQ_STAT) ?
               (wb_dat_in[2:0] & wm[2:0]) : 3'h0;

  // Status, interrupt line and power-down edge memory
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_stat_ff <= 3'h0;
      irq_ff      <= 1'b0;
      pdn_prev_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
      irq_ff      <= |(irq_stat_ff & irq_mask_ff);
      pdn_prev_ff <= pdn_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_out          = data_ff;
  assign data_oe_out       = data_oe_ff;
  assign range_flag_out    = range_ff;
  assign data_clock_out    = dclk_ff;
  assign data_clock_oe_out = dclk_oe_ff;
  assign wb_dat_out        = dat_ff;
  assign wb_ack_out        = ack_ff;
  assign irq_out           = irq_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  logic [12:0] ob_view;
  assign ob_view = data_ff ^ {fmt_ff, 12'h000};

  sequence s_edge;
    (rise && pdn_s) ##1 (stage_vld_ff && pdn_s);
  endsequence

  a_edge_only_update: assert property (
    ($changed(data_ff) && pdn_s && $past(pdn_s)) |-> $past(stage_vld_ff))
    else $error("word changed without an input clock rising edge");
  a_tristate_data: assert property (
    oen_s |=> (data_oe_ff == 13'h0000))
    else $error("data driven while output enable low is high");
  a_mid_scale_zero: assert property (
    (rise && pdn_s && raw_sample_in == 14'h0000)
      |=> (corr_ff == $signed({3'b000, afo_pkg::MID_CODE}) - $past(trim_ext)))
    else $error("zero input not centred on mid-scale");
  a_clamp_over_range: assert property (
    (stage_vld_ff && pdn_s && corr_ff > hi_lim)
      |=> (range_ff && ob_view == afo_pkg::ALL_ONES))
    else $error("over-range not clamped to all ones");
  a_clamp_under_range: assert property (
    (stage_vld_ff && pdn_s && corr_ff < 16'sh0000)
      |=> (range_ff && ob_view == afo_pkg::ALL_ZEROS))
    else $error("under-range not clamped to all zeros");
  a_flag_full_word: assert property (
    (stage_vld_ff && pdn_s && !twelve_ff)
      |=> (range_ff == ((&ob_view) | ~(|ob_view))))
    else $error("range flag disagrees with thirteen-bit word");
  a_flag_twelve_bit: assert property (
    (pdn_s && twelve_ff && $stable(twelve_ff))
      |-> (range_ff == (((&ob_view[12:1]) | ~(|ob_view[12:1]))
                        && ob_view[0] == ob_view[1])))
    else $error("range flag disagrees with twelve-bit word");
  a_format_msb_code: assert property (
    (stage_vld_ff && pdn_s)
      |=> (data_ff[12] == ($past(nxt_ob[12]) ^ $past(fmt_s))
           && data_ff[11:0] == $past(nxt_ob[11:0])))
    else $error("output coding does not follow format select");
  a_power_down_zero: assert property (
    !pdn_s |=> (data_ff == 13'h0000 && !range_ff && !dclk_ff))
    else $error("outputs not zero in power-down");
  a_clock_out_enable: assert property (
    cken_s |=> !dclk_oe_ff)
    else $error("data clock driven while disabled");
  a_pipe_latency: assert property (
    s_edge |=> upd_ff)
    else $error("word not updated two cycles after the edge");

endmodule : afo_formatter

// ---- afo_rx_model.sv ----
// Receiving-logic model that captures parallel sample words
`timescale 1ns/1ps
module afo_rx_model (
  // Pins from the formatter
  input  wire logic [12:0] data_pin_in,
  input  wire logic        data_clock_in,
  // Receiver configuration
  input  wire logic        twelve_bit_in,
  // Captured sample
  output logic      [12:0] word_out
);
  // Capture on data clock rise; bit 0 is not wired in twelve-bit use
  always_ff @(posedge data_clock_in) begin
    if (twelve_bit_in) begin
      word_out <= {data_pin_in[12:1], 1'b0};
    end else begin
      word_out <= data_pin_in;
    end
  end
endmodule : afo_rx_model

// ---- afo_formatter_tb.sv ----
// Self-checking bench for the sample output formatter
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module afo_formatter_tb;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        sclk   = 1'b0;
  logic [13:0] raw_s  = 14'h0000;
  logic        fmt_s  = 1'b0;
  logic        oe_n   = 1'b0;
  logic        pd_n   = 1'b1;
  logic        ck_n   = 1'b0;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic [7:0]  adr    = 8'h00;
  logic [3:0]  sel    = 4'h0;
  logic [31:0] wdat   = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic [12:0] data_q;
  logic [12:0] data_oe;
  logic        range_q;
  logic        dclk;
  logic        dclk_oe;
  wire  [12:0] data_pin;
  wire         dclk_pin;
  logic [12:0] rx_word;
  logic        twelve = 1'b0;
  logic [31:0] rv;
  int          trim   = 0;
  int          fails  = 0;
  int          tests_run = 0;

  // Clocks: system 40 ns, converter clock 320 ns with an unrelated phase
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #7;
    forever #160 sclk = ~sclk;
  end

  // Pin levels seen by the receiver
  for (genvar i = 0; i < 13; i++) begin : g_pin
    assign data_pin[i] = data_oe[i] ? data_q[i] : 1'bz;
  end
  assign dclk_pin = dclk_oe ? dclk : 1'bz;

  afo_formatter dut_u (
    .ref_clk_in(clk), .sys_rst_in(rst), .sample_clk_in(sclk), .raw_sample_in(raw_s),
    .format_select_in(fmt_s), .output_enable_low_in(oe_n), .power_down_low_in(pd_n),
    .data_clock_out_enable_low_in(ck_n), .data_out(data_q), .data_oe_out(data_oe),
    .range_flag_out(range_q), .data_clock_out(dclk), .data_clock_oe_out(dclk_oe),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq)
  );

  afo_rx_model rx_u (
    .data_pin_in(data_pin), .data_clock_in(dclk_pin), .twelve_bit_in(twelve),
    .word_out(rx_word)
  );

  // ----------------------------------------------------------------
  // Bus and sample helpers
  // ----------------------------------------------------------------
  // Classic cycle; request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask : wb

  // Raw value changes mid-period so it is stable around each rise
  task automatic put(input int raw, input logic fmt);
    @(negedge sclk);
    @(posedge clk);
    raw_s <= 14'(raw);
    fmt_s <= fmt;
    repeat (3) @(posedge sclk);
    repeat (12) @(posedge clk);
  endtask : put

  task automatic expect_word(input int raw, input logic fmt);
    int          corr;
    logic [12:0] w;
    logic [12:0] rw;
    logic        f;
    put(raw, fmt);
    corr = 4096 + raw - trim;
    f = (corr >= 8191) || (corr <= 0);
    w = (corr > 8191) ? afo_pkg::ALL_ONES : (corr < 0) ? afo_pkg::ALL_ZEROS : 13'(corr);
    w[afo_pkg::MSB_POS] = w[afo_pkg::MSB_POS] ^ fmt;
    rw = twelve ? {w[12:1], 1'b0} : w;
    `CHK(data_q, w)
    `CHK(range_q, f)
    `CHK(rx_word, rw)
  endtask : expect_word

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    wb(1'b0, afo_pkg::ADR_CTRL, 32'h0, rv);
    `CHK(rv, 32'h0000_0000)
    wb(1'b0, afo_pkg::ADR_TRIM, 32'h0, rv);
    `CHK(rv, 32'h0000_0000)
    wb(1'b0, afo_pkg::ADR_IRQ_MASK, 32'h0, rv);
    `CHK(rv, 32'h0000_0000)
    wb(1'b1, 8'h20, 32'hffff_ffff, rv);
    wb(1'b0, 8'h20, 32'h0, rv);
    `CHK(rv, 32'h0000_0000)
    `CHK(irq, 1'b0)
  endtask : t_reset

  task automatic t_codes();
    int vals[9] = '{0, 1, -1, 4095, -4096, 8191, -8192, -5000, 5000};
    for (int f = 0; f < 2; f++) begin
      foreach (vals[i]) expect_word(vals[i], 1'(f));
    end
    wb(1'b0, afo_pkg::ADR_STAT, 32'h0, rv);
    `CHK(rv[16], 1'b1)
  endtask : t_codes

  task automatic t_trim();
    wb(1'b1, afo_pkg::ADR_TRIM, 32'h5, rv);
    trim = 5;
    wb(1'b0, afo_pkg::ADR_TRIM, 32'h0, rv);
    `CHK(rv[13:0], 14'h0005)
    expect_word(5, 1'b0);
    expect_word(-3, 1'b1);
    wb(1'b1, afo_pkg::ADR_TRIM, 32'h0, rv);
    trim = 0;
  endtask : t_trim

  // Over-range is unmasked, under-range stays masked
  task automatic t_irq();
    wb(1'b1, afo_pkg::ADR_IRQ_MASK, 32'h1, rv);
    put(5000, 1'b0);
    `CHK(irq, 1'b1)
    put(0, 1'b0);
    wb(1'b1, afo_pkg::ADR_IRQ_STAT, 32'h1, rv);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    put(-5000, 1'b0);
    `CHK(irq, 1'b0)
    wb(1'b0, afo_pkg::ADR_IRQ_STAT, 32'h0, rv);
    `CHK(rv[2:0], 3'h2)
    put(0, 1'b0);
    wb(1'b1, afo_pkg::ADR_IRQ_STAT, 32'h7, rv);
    wb(1'b1, afo_pkg::ADR_IRQ_MASK, 32'h0, rv);
  endtask : t_irq

  // Word 0001 is not out of range in twelve-bit use
  task automatic t_twelve();
    wb(1'b1, afo_pkg::ADR_CTRL, 32'h1, rv);
    twelve = 1'b1;
    expect_word(-4096, 1'b0);
    expect_word(-4095, 1'b0);
    `CHK(data_oe, 13'h1fff)
    wb(1'b1, afo_pkg::ADR_CTRL, 32'h0, rv);
    twelve = 1'b0;
  endtask : t_twelve

  task automatic t_enables();
    @(posedge clk);
    oe_n <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(data_oe, 13'h0000)
    `CHK(dclk_oe, 1'b1)
    ck_n <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(dclk_oe, 1'b0)
    oe_n <= 1'b0;
    ck_n <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(data_oe, 13'h1fff)
  endtask : t_enables

  // Four converter periods must give exactly four data clock rises
  task automatic t_edges();
    int   n;
    logic prev;
    n = 0;
    @(posedge sclk);
    @(posedge clk);
    prev = dclk;
    repeat (32) begin
      @(posedge clk);
      if (dclk === 1'b1 && prev === 1'b0) n++;
      prev = dclk;
    end
    `CHK(n, 4)
  endtask : t_edges

  task automatic t_pdown();
    put(5000, 1'b0);
    @(posedge clk);
    pd_n <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(data_q, 13'h0000)
    `CHK(range_q, 1'b0)
    `CHK(dclk, 1'b0)
    wb(1'b0, afo_pkg::ADR_IRQ_STAT, 32'h0, rv);
    `CHK(rv[2], 1'b1)
    wb(1'b1, afo_pkg::ADR_COUNT, 32'h0, rv);
    wb(1'b0, afo_pkg::ADR_COUNT, 32'h0, rv);
    `CHK(rv[15:0], 16'h0000)
    pd_n <= 1'b1;
  endtask : t_pdown

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic results();
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_reset();
    t_codes();
    t_trim();
    t_irq();
    t_twelve();
    t_enables();
    t_edges();
    t_pdown();
    results();
  end

  // Run needs about 1100 cycles; this allows several times that
  initial begin
    #400000;
    fails++;
    results();
  end
endmodule : afo_formatter_tb
